// >>> include/fes_pkg.sv
package fes_pkg;

    // Address layout of the flash window on the register bus.
    localparam int FLASH_AW = 16;
    localparam int WORD_AW  = FLASH_AW - 2;
    localparam int SECT_W   = 3;
    localparam int NUM_SECT = 8;
    localparam int CNT_W    = 24;

    // Unlock cycles, word address and data, for steps zero to four.
    localparam logic [WORD_AW-1:0] UNL_ADDR_A = 14'h0555;
    localparam logic [WORD_AW-1:0] UNL_ADDR_B = 14'h02aa;
    localparam logic [WORD_AW-1:0] SEQ_ADDR [5] = '{UNL_ADDR_A, UNL_ADDR_B, UNL_ADDR_A, UNL_ADDR_A, UNL_ADDR_B};
    localparam logic [7:0]         SEQ_DATA [5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
    localparam logic [2:0]         SEQ_LAST     = 3'h5;

    // Command codes.
    localparam logic [7:0] CMD_CHIP   = 8'h10;
    localparam logic [7:0] CMD_SECT   = 8'h30;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] CMD_SUSP   = 8'hb0;
    localparam logic [7:0] CMD_RESET  = 8'hf0;

    // Status bit positions.
    localparam int POLL_BIT = 7;
    localparam int TOG_BIT  = 6;
    localparam int TMO_BIT  = 5;
    localparam int WIN_BIT  = 3;
    localparam int ETOG_BIT = 2;

    // Timing.
    localparam int CLK_MHZ        = 100;
    localparam int SEL_WAIT_US    = 50;
    localparam int SUSP_MAX_US    = 15;
    localparam int SEL_WAIT_CYC   = SEL_WAIT_US * CLK_MHZ;
    localparam int SUSP_MAX_CYC   = SUSP_MAX_US * CLK_MHZ;
    localparam int PREPROG_CYC_DF = 8192;
    localparam int ERASE_CYC_DF   = 32768;

    // Bus responses and reset values.
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [2:0]  SEQ_RST     = 3'h0;
    localparam logic [31:0] DATA_RST    = 32'h0000_0000;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_SELW  = 6'b000010,
        ST_CHIP  = 6'b000100,
        ST_SECT  = 6'b001000,
        ST_SPEND = 6'b010000,
        ST_SUSP  = 6'b100000
    } fes_state_t;

endpackage

// >>> include/fes_sel_if.sv
`timescale 1ns/100ps
interface fes_sel_if;
    import fes_pkg::*;
    logic                clear;
    logic                set_all;
    logic                set_en;
    logic [SECT_W-1:0]   set_idx;
    logic [SECT_W-1:0]   q_idx;
    logic                q_hit;
    logic [NUM_SECT-1:0] mask;
    modport ctrl  (output clear, set_all, set_en, set_idx, q_idx, input q_hit, mask);
    modport store (input clear, set_all, set_en, set_idx, q_idx, output q_hit, mask);
endinterface

// >>> rtl/fes_sector_sel.sv
`timescale 1ns/100ps
module fes_sector_sel
    import fes_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_in,
    input  wire logic sys_rst_in,
    // Control side
    fes_sel_if.store  sel
);

    logic [NUM_SECT-1:0] mask_reg;

    genvar s;
    generate
        for (s = 0; s < NUM_SECT; s++) begin : g_sect
            // A set in the same cycle as a clear wins, so a new selection is never lost.
            always_ff @(posedge mclk_in) begin
                if (sys_rst_in) begin
                    mask_reg[s] <= 1'b0;
                end else if (sel.set_all || (sel.set_en && sel.set_idx == SECT_W'(s))) begin
                    mask_reg[s] <= 1'b1;
                end else if (sel.clear) begin
                    mask_reg[s] <= 1'b0;
                end
            end
        end
    endgenerate

    assign sel.mask  = mask_reg;
    assign sel.q_hit = mask_reg[sel.q_idx];

endmodule

// >>> rtl/fes_top.sv
// The AXI4-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module fes_top
    import fes_pkg::*;
#(
    parameter int SEL_WAIT_CYCLES = SEL_WAIT_CYC,
    parameter int SUSP_LAT_CYCLES = SUSP_MAX_CYC,
    parameter int PREPROG_CYCLES  = PREPROG_CYC_DF,
    parameter int ERASE_CYCLES    = ERASE_CYC_DF
)
(
    // Clock and reset
    input  wire logic                mclk_in,
    input  wire logic                sys_rst_in,
    // AXI4-Lite write channels
    input  wire logic [31:0]         s_axi_awaddr_in,
    input  wire logic                s_axi_awvalid_in,
    output logic                     s_axi_awready_out,
    input  wire logic [31:0]         s_axi_wdata_in,
    input  wire logic [3:0]          s_axi_wstrb_in,
    input  wire logic                s_axi_wvalid_in,
    output logic                     s_axi_wready_out,
    output logic [1:0]               s_axi_bresp_out,
    output logic                     s_axi_bvalid_out,
    input  wire logic                s_axi_bready_in,
    // AXI4-Lite read channels
    input  wire logic [31:0]         s_axi_araddr_in,
    input  wire logic                s_axi_arvalid_in,
    output logic                     s_axi_arready_out,
    output logic [31:0]              s_axi_rdata_out,
    output logic [1:0]               s_axi_rresp_out,
    output logic                     s_axi_rvalid_out,
    input  wire logic                s_axi_rready_in,
    // Flash array
    input  wire logic [15:0]         array_rdata_in,
    input  wire logic                array_fault_in,
    output logic [WORD_AW-1:0]       array_addr_out,
    output logic                     array_preprog_out,
    output logic                     array_erase_out,
    output logic [NUM_SECT-1:0]      array_sector_mask_out
);

    fes_sel_if sel ();

    fes_sector_sel u_sel (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .sel        (sel.store)
    );

    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(SEL_WAIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] SUSP_LAST = CNT_W'(SUSP_LAT_CYCLES - 1);
    localparam logic [CNT_W-1:0] PRE_END   = CNT_W'(PREPROG_CYCLES);
    localparam logic [CNT_W-1:0] RUN_LAST  = CNT_W'(PREPROG_CYCLES + ERASE_CYCLES - 1);

    fes_state_t          state_reg;
    fes_state_t          state_next;
    logic                aw_full_reg;
    logic [31:0]         aw_addr_reg;
    logic                w_full_reg;
    logic [7:0]          w_byte_reg;
    logic                w_lane0_reg;
    logic                bvalid_reg;
    logic [1:0]          bresp_reg;
    logic                rd_pend_reg;
    logic [31:0]         rd_addr_reg;
    logic                rvalid_reg;
    logic [31:0]         rdata_reg;
    logic [1:0]          rresp_reg;
    logic [2:0]          seq_reg;
    logic [CNT_W-1:0]    tmr_reg;
    logic [CNT_W-1:0]    run_reg;
    logic                timeout_reg;
    logic                toggle_reg;
    logic                etoggle_reg;
    logic                preprog_reg;
    logic                erase_reg;
    logic [NUM_SECT-1:0] smask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    wire aw_take  = s_axi_awvalid_in & ~aw_full_reg;
    wire w_take   = s_axi_wvalid_in & ~w_full_reg;
    wire cmd_fire = aw_full_reg & w_full_reg & ~bvalid_reg;
    wire ar_take  = s_axi_arvalid_in & ~rd_pend_reg & ~rvalid_reg;

    wire                 cmd_in_rng = aw_addr_reg[31:FLASH_AW] == '0;
    wire                 cmd_ok     = cmd_fire & cmd_in_rng & w_lane0_reg;
    wire [WORD_AW-1:0]   cmd_word   = aw_addr_reg[FLASH_AW-1:2];
    wire [SECT_W-1:0]    cmd_sect   = cmd_word[WORD_AW-1 -: SECT_W];
    wire                 cmd_even   = aw_addr_reg[1:0] == 2'b00;
    wire                 rd_in_rng  = rd_addr_reg[31:FLASH_AW] == '0;

    wire st_idle  = state_reg == ST_IDLE;
    wire st_selw  = state_reg == ST_SELW;
    wire st_chip  = state_reg == ST_CHIP;
    wire st_sect  = state_reg == ST_SECT;
    wire st_spend = state_reg == ST_SPEND;
    wire st_susp  = state_reg == ST_SUSP;
    wire running  = st_chip | st_sect | st_spend;

    ////////////////////////////////////////////////////////////////////////////
    // Command recognition

    wire unlock_hit = cmd_ok & st_idle & (seq_reg < SEQ_LAST) & (cmd_word == SEQ_ADDR[seq_reg])
                      & (w_byte_reg == SEQ_DATA[seq_reg]);
    wire last_step  = cmd_ok & st_idle & (seq_reg == SEQ_LAST);
    wire chip_go    = last_step & (cmd_word == UNL_ADDR_A) & (w_byte_reg == CMD_CHIP);
    wire sect_go    = last_step & cmd_even & (w_byte_reg == CMD_SECT);
    wire sel_add    = cmd_ok & st_selw & (w_byte_reg == CMD_SECT);
    wire susp_cmd   = cmd_ok & (st_selw | st_sect) & (w_byte_reg == CMD_SUSP);
    wire resume_cmd = cmd_ok & st_susp & (w_byte_reg == CMD_RESUME);
    wire reset_cmd  = cmd_ok & (w_byte_reg == CMD_RESET);
    wire wait_done  = st_selw & (tmr_reg == WAIT_LAST);
    wire susp_done  = st_spend & (tmr_reg == SUSP_LAST);
    wire run_step   = running & ~timeout_reg;
    wire run_done   = run_step & (run_reg == RUN_LAST);
    wire in_preprog = run_reg < PRE_END;

    // Any access that is not the expected next unlock write restarts the count.
    wire seq_keep   = unlock_hit & ~ar_take;
    wire [2:0] seq_next = seq_keep ? seq_reg + 3'h1 : ((cmd_fire | ar_take) ? SEQ_RST : seq_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (chip_go) begin
                    state_next = ST_CHIP;
                end else if (sect_go) begin
                    state_next = ST_SELW;
                end
            end
            ST_SELW: begin
                if (susp_cmd) begin
                    state_next = ST_SUSP;
                end else if (wait_done && !sel_add) begin
                    state_next = ST_SECT;
                end
            end
            ST_CHIP: begin
                if (run_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_SECT: begin
                if (run_done) begin
                    state_next = ST_IDLE;
                end else if (susp_cmd) begin
                    state_next = ST_SPEND;
                end
            end
            ST_SPEND: begin
                if (run_done) begin
                    state_next = ST_IDLE;
                end else if (susp_done) begin
                    state_next = ST_SUSP;
                end
            end
            ST_SUSP: begin
                if (resume_cmd) begin
                    state_next = ST_SECT;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (reset_cmd) begin
            state_next = ST_IDLE;
        end
    end

    // Suspend in chip erase, a second suspend and resume while erasing are not decoded.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            state_reg <= ST_IDLE;
            seq_reg   <= SEQ_RST;
        end else begin
            state_reg <= state_next;
            seq_reg   <= seq_next;
        end
    end

    // One timer serves both the selection window and the suspend latency.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            tmr_reg <= '0;
        end else if (sect_go || sel_add || susp_cmd) begin
            tmr_reg <= '0;
        end else if (st_selw || st_spend) begin
            tmr_reg <= tmr_reg + 1'b1;
        end
    end

    // The erase progress is kept across a suspension so that resume continues.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            run_reg <= '0;
        end else if (chip_go || sect_go || reset_cmd) begin
            run_reg <= '0;
        end else if (run_step && !run_done) begin
            run_reg <= run_reg + 1'b1;
        end
    end

    // A fault in the same cycle as a reset command still sets the flag.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            timeout_reg <= 1'b0;
        end else begin
            timeout_reg <= (running & array_fault_in) | (timeout_reg & ~reset_cmd & ~chip_go & ~sect_go);
        end
    end

    assign sel.clear   = chip_go | sect_go | reset_cmd | run_done;
    assign sel.set_all = chip_go;
    assign sel.set_en  = sect_go | sel_add;
    assign sel.set_idx = cmd_sect;
    assign sel.q_idx   = rd_addr_reg[FLASH_AW-1 -: SECT_W];

    // Zero programming always precedes the erase pulse of the same run.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            preprog_reg <= 1'b0;
            erase_reg   <= 1'b0;
            smask_reg   <= '0;
        end else begin
            preprog_reg <= run_step & in_preprog & ~run_done;
            erase_reg   <= run_step & ~in_preprog & ~run_done;
            smask_reg   <= sel.mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channels

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= DATA_RST;
            w_full_reg  <= 1'b0;
            w_byte_reg  <= 8'h00;
            w_lane0_reg <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_in;
            end else if (cmd_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (w_take) begin
                w_full_reg  <= 1'b1;
                w_byte_reg  <= s_axi_wdata_in[7:0];
                w_lane0_reg <= s_axi_wstrb_in[0];
            end else if (cmd_fire) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (cmd_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= cmd_in_rng ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channels

    wire show_stat = ~st_idle & ~(st_susp & ~sel.q_hit);
    wire tog_run   = st_selw | (running & ~timeout_reg);
    wire etog_run  = sel.q_hit & (running | st_selw | st_susp);

    wire [7:0] stat_byte;
    assign stat_byte[POLL_BIT] = ~tog_run;
    assign stat_byte[TOG_BIT]  = toggle_reg;
    assign stat_byte[TMO_BIT]  = timeout_reg;
    assign stat_byte[4]        = 1'b0;
    assign stat_byte[WIN_BIT]  = ~st_selw;
    assign stat_byte[ETOG_BIT] = etoggle_reg;
    assign stat_byte[1:0]      = 2'b00;

    wire [31:0] rd_word = ~rd_in_rng ? DATA_RST :
                          (show_stat ? {24'h000000, stat_byte} : {16'h0000, array_rdata_in});

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rd_pend_reg <= 1'b0;
            rd_addr_reg <= DATA_RST;
        end else if (ar_take) begin
            rd_pend_reg <= 1'b1;
            rd_addr_reg <= s_axi_araddr_in;
        end else begin
            rd_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= DATA_RST;
            rresp_reg  <= RESP_OKAY;
        end else if (rd_pend_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_in_rng ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_in) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Each status read advances the toggles; the main toggle holds while suspended or timed out, the second one on reads outside the selected sectors.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            toggle_reg  <= 1'b0;
            etoggle_reg <= 1'b0;
        end else if (rd_pend_reg && rd_in_rng && show_stat) begin
            toggle_reg  <= toggle_reg ^ tog_run;
            etoggle_reg <= etoggle_reg ^ etog_run;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            array_addr_out <= '0;
        end else if (ar_take) begin
            array_addr_out <= s_axi_araddr_in[FLASH_AW-1:2];
        end
    end

    assign s_axi_awready_out     = ~aw_full_reg;
    assign s_axi_wready_out      = ~w_full_reg;
    assign s_axi_bvalid_out      = bvalid_reg;
    assign s_axi_bresp_out       = bresp_reg;
    assign s_axi_arready_out     = ~rd_pend_reg & ~rvalid_reg;
    assign s_axi_rvalid_out      = rvalid_reg;
    assign s_axi_rdata_out       = rdata_reg;
    assign s_axi_rresp_out       = rresp_reg;
    assign array_preprog_out     = preprog_reg;
    assign array_erase_out       = erase_reg;
    assign array_sector_mask_out = smask_reg;

endmodule

// >>> dv/fes_chk.sv
`timescale 1ns/100ps
module fes_chk
    import fes_pkg::*;
(
    // Clock and reset
    input wire logic                mclk_in,
    input wire logic                sys_rst_in,
    // Register bus
    input wire logic                s_axi_awvalid_in,
    input wire logic                s_axi_awready_out,
    input wire logic                s_axi_wvalid_in,
    input wire logic                s_axi_wready_out,
    input wire logic [1:0]          s_axi_bresp_out,
    input wire logic                s_axi_bvalid_out,
    input wire logic                s_axi_bready_in,
    input wire logic [31:0]         s_axi_araddr_in,
    input wire logic                s_axi_arvalid_in,
    input wire logic                s_axi_arready_out,
    input wire logic [31:0]         s_axi_rdata_out,
    input wire logic                s_axi_rvalid_out,
    input wire logic                s_axi_rready_in,
    // Flash array
    input wire logic [WORD_AW-1:0]  array_addr_out,
    input wire logic                array_preprog_out,
    input wire logic                array_erase_out,
    input wire logic [NUM_SECT-1:0] array_sector_mask_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    ////////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
        s_axi_wready_out && !s_axi_bvalid_out |=> ##1 s_axi_bvalid_out) else $error("write answer late");
    a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
        s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
        !s_axi_arready_out ##1 s_axi_rvalid_out) else $error("read answer late");
    a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
        s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
    a_addr_capture: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in[31:16] == 16'h0
        |=> array_addr_out == $past(s_axi_araddr_in[15:2])) else $error("array address wrong");
    a_phase_excl: assert property (!(array_preprog_out && array_erase_out))
        else $error("preprogram and erase overlap");
    a_erase_mask: assert property (array_erase_out |-> array_sector_mask_out != 8'h00)
        else $error("erase without sectors");
    // A changed sector selection restarts the window, so the run cannot follow at once.
    a_window_wait: assert property ($changed(array_sector_mask_out) && array_sector_mask_out != 8'hff &&
        array_sector_mask_out != 8'h00 |=> !array_preprog_out [*8]) else $error("erase started early");
    c_erase: cover property ($rose(array_erase_out));
    c_preprog: cover property ($rose(array_preprog_out));
    c_stop: cover property ($fell(array_erase_out) && array_sector_mask_out != 8'hff);
endmodule
bind fes_top fes_chk chk_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
    .array_addr_out(array_addr_out), .array_preprog_out(array_preprog_out), .array_erase_out(array_erase_out),
    .array_sector_mask_out(array_sector_mask_out));

// >>> dv/fes_array_model.sv
`timescale 1ns/100ps
module fes_array_model
    import fes_pkg::*;
(
    // Array access
    input  wire logic [WORD_AW-1:0] addr_in,
    input  wire logic               fault_req_in,
    output logic [15:0]             rdata_out,
    output logic                    fault_out
);
    // Each word reads back a value derived from its index, so a stale address shows.
    assign rdata_out = {2'b01, addr_in};
    assign fault_out = fault_req_in;
endmodule

// >>> dv/tb.sv
`timescale 1ns/100ps
module tb;
    import fes_pkg::*;
    logic               clk = 1'b0, rst = 1'b1;
    logic [31:0]        awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rdat, d0;
    logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic               awready, wready, bvalid, arready, rvalid, preprog, erase, fault, fault_req = 1'b0;
    logic [1:0]         bresp, rresp, wrsp, rrsp;
    logic [15:0]        arr_rdata;
    logic [WORD_AW-1:0] arr_addr;
    logic [7:0]         mask;
    int                 bad_count = 0, compares = 0, cycles = 0;
    always #5 clk = ~clk;
    fes_top #(.SEL_WAIT_CYCLES(20), .SUSP_LAT_CYCLES(4), .PREPROG_CYCLES(8), .ERASE_CYCLES(64)) dut_u (
        .mclk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .array_rdata_in(arr_rdata), .array_fault_in(fault), .array_addr_out(arr_addr),
        .array_preprog_out(preprog), .array_erase_out(erase), .array_sector_mask_out(mask));
    fes_array_model mdl_u (.addr_in(arr_addr), .fault_req_in(fault_req), .rdata_out(arr_rdata), .fault_out(fault));
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic chkb(input string name, input logic seen, input logic exp);
        chk(name, {31'h0, seen}, {31'h0, exp});
    endtask
    function automatic logic [31:0] arr_word(input logic [31:0] a);
        return {16'h0, 2'b01, a[15:2]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        wrsp = bresp;
        bready <= 1'b0;
        // Step off the edge so that callers see the flops it has just updated.
        #1;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rdat = rdata;
        rrsp = rresp;
        rready <= 1'b0;
    endtask
    // A bad index below five corrupts that unlock step; rd_mid slips a read into the sequence.
    task automatic unlock(input int bad, input bit rd_mid);
        for (int i = 0; i < 5; i++) begin
            if (rd_mid && i == 2) rd(32'h40);
            wr({16'h0, SEQ_ADDR[i], 2'b00}, SEQ_DATA[i] ^ 8'(i == bad));
        end
    endtask
    task automatic wait_idle();
        while (preprog || erase) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_chip();
        unlock(5, 1'b0);
        wr(32'h1554, CMD_CHIP);
        chk("chip mask", {24'h0, mask}, 32'hff);
        repeat (2) @(posedge clk);
        chkb("preprog first", preprog, 1'b1);
        wr(32'h0040, CMD_SUSP);
        repeat (4) @(posedge clk);
        chkb("chip ignores suspend", preprog | erase, 1'b1);
        rd(32'h0040);
        chkb("chip busy poll", rdat[POLL_BIT], 1'b0);
        wait_idle();
        rd(32'h0040);
        chk("chip done read", rdat, arr_word(32'h40));
    endtask
    task automatic t_sector();
        unlock(5, 1'b0);
        wr(32'h4000, CMD_SECT);
        rd(32'h4000);
        chkb("window open", rdat[WIN_BIT], 1'b0);
        wr(32'ha000, CMD_SECT);
        chk("two sectors", {24'h0, mask}, 32'h24);
        repeat (25) @(posedge clk);
        chkb("run after window", preprog | erase, 1'b1);
        rd(32'h4000);
        d0 = rdat;
        rd(32'h4000);
        chkb("window shut", rdat[WIN_BIT], 1'b1);
        chkb("toggle runs", rdat[TOG_BIT] ^ d0[TOG_BIT], 1'b1);
        wr(32'he000, CMD_SECT);
        chk("late select refused", {24'h0, mask}, 32'h24);
        chkb("resume ignored", preprog | erase, 1'b1);
        wr(32'h0100, CMD_SUSP);
        repeat (6) @(posedge clk);
        chkb("suspended", preprog | erase, 1'b0);
        rd(32'h4000);
        d0 = rdat;
        rd(32'h4000);
        chkb("main toggle still", rdat[TOG_BIT] ^ d0[TOG_BIT], 1'b0);
        chkb("second toggle runs", rdat[ETOG_BIT] ^ d0[ETOG_BIT], 1'b1);
        rd(32'h0100);
        chk("other sector data", rdat, arr_word(32'h100));
        wr(32'h0100, CMD_SUSP);
        repeat (6) @(posedge clk);
        chkb("second suspend", preprog | erase, 1'b0);
        wr(32'h0100, CMD_RESUME);
        repeat (2) @(posedge clk);
        chkb("resumed", preprog | erase, 1'b1);
        wait_idle();
        rd(32'h4000);
        chk("sector done read", rdat, arr_word(32'h4000));
    endtask
    task automatic t_stop_and_fault();
        unlock(5, 1'b0);
        wr(32'h2000, CMD_SECT);
        wr(32'h2000, CMD_SUSP);
        repeat (30) @(posedge clk);
        chkb("stopped in window", preprog | erase, 1'b0);
        wr(32'h2000, CMD_RESET);
        rd(32'h2000);
        chk("reset after stop", rdat, arr_word(32'h2000));
        unlock(5, 1'b0);
        wr(32'h6000, CMD_SECT);
        repeat (25) @(posedge clk);
        fault_req <= 1'b1;
        rd(32'h6000);
        d0 = rdat;
        rd(32'h6000);
        chkb("timeout flag", rdat[TMO_BIT], 1'b1);
        chkb("poll with timeout", rdat[POLL_BIT], 1'b1);
        chkb("toggle stops", rdat[TOG_BIT] ^ d0[TOG_BIT], 1'b0);
        fault_req <= 1'b0;
        wr(32'h6000, CMD_RESET);
        rd(32'h6000);
        chk("reset after fault", rdat, arr_word(32'h6000));
    endtask
    task automatic t_broken();
        for (int b = 0; b < 6; b++) begin
            unlock(b, b == 5);
            wr(32'h1554, CMD_CHIP);
            repeat (3) @(posedge clk);
            chkb("broken sequence", preprog | erase, 1'b0);
        end
        wr(32'h0001_0000, CMD_RESET);
        chk("unmapped write", {30'h0, wrsp}, {30'h0, RESP_SLVERR});
        rd(32'h0001_0000);
        chk("unmapped read", {rrsp, rdat[29:0]}, {RESP_SLVERR, 30'h0});
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(32'h0040);
        chk("reset read", rdat, arr_word(32'h40));
        t_broken();
        t_chip();
        t_sector();
        t_stop_and_fault();
        report_and_stop();
    end
endmodule
